/* File: ioc_trip_regs.svh */
// register offsets, field positions, reset values and counts of the overcurrent trip block
`ifndef IOC_TRIP_REGS_SVH
`define IOC_TRIP_REGS_SVH

// byte offsets on the register bus
`define IOC_CTRL_OFS 8'h00
`define IOC_THR_OFS 8'h04
`define IOC_STAT_OFS 8'h08
`define IOC_PEAK_A_OFS 8'h0c
`define IOC_PEAK_B_OFS 8'h10
`define IOC_PEAK_C_OFS 8'h14

// control fields
`define IOC_CTRL_MODE_LSB 0
`define IOC_CTRL_MODE_W 2

// status fields
`define IOC_STAT_TRIP_LSB 0
`define IOC_STAT_GEN_BIT 3
`define IOC_STAT_DIS_BIT 4
`define IOC_STAT_DBL_BIT 5

// start threshold in percent of rated current
`define IOC_THR_W 12
`define IOC_THR_MIN 12'h014
`define IOC_THR_MAX 12'hbb8
`define IOC_THR_RST 12'h0c8

// samples per peak window, one network period
`define IOC_PEAK_WINDOW 8'h14

`endif

/* File: ioc_trip_pkg.sv */
// types shared by the overcurrent trip block
`default_nettype none
package ioc_trip_pkg;

  // operation selector
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_PEAK = 2'h1,
    MODE_FUND = 2'h2
  } mode_e;

  // one phase's measurement, both in units of 1 % of rated current
  typedef struct packed {
    logic signed [15:0] sample;
    logic [15:0] fund_rms;
  } phase_meas_s;

  // trip flags as seen by the relay logic
  typedef struct packed {
    logic general;
    logic [2:0] phase;
  } trip_s;

endpackage : ioc_trip_pkg
`default_nettype wire

/* File: instant_overcurrent_function.sv */
// three-phase instantaneous overcurrent trip decision with wishbone register access
//
// Overview of operation
// - selector off, peak or fundamental; off clears trips
// - start threshold percent, 20 to 3000, default 200
// - double input compares against twice the threshold
// - disable input suppresses every trip output
// - phase trips at once when value exceeds threshold
// - peak mode uses peak, fundamental mode uses RMS
// - peak derived per phase from its samples
// - general trip built only from phase trips
// - general trip is OR of three phases
`timescale 1ns/1ps
`default_nettype none
`include "ioc_trip_regs.svh"

module instant_overcurrent_function (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // sample set from the front end
  input wire logic sample_strobe_i,
  input wire ioc_trip_pkg::phase_meas_s [2:0] meas_i,
  // relay logic pins
  input wire logic function_disable_input_i,
  input wire logic threshold_double_input_i,
  output ioc_trip_pkg::trip_s trip_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic dis_meta_q;
  logic dis_q;
  logic dbl_meta_q;
  logic dbl_q;

  // first stage feeds only the second; pins may change at any time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dis_meta_q <= 1'b0;
      dis_q <= 1'b0;
      dbl_meta_q <= 1'b0;
      dbl_q <= 1'b0;
    end
    else
    begin
      dis_meta_q <= function_disable_input_i;
      dis_q <= dis_meta_q;
      dbl_meta_q <= threshold_double_input_i;
      dbl_q <= dbl_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  ioc_trip_pkg::mode_e mode_q;
  logic [`IOC_THR_W-1:0] thr_q;
  logic [15:0] peak_q [3];
  logic acc;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] ctrl_img;
  logic [31:0] thr_img;
  logic [31:0] stat_img;
  logic [31:0] ctrl_m;
  logic [31:0] thr_m;

  assign acc = cyc_i && stb_i && !ack_o;
  assign wr = acc && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ctrl_img = {30'h0, mode_q};
  assign thr_img = {20'h0, thr_q};
  assign stat_img = {26'h0, dbl_q, dis_q, trip_o.general, trip_o.phase};
  // byte lanes merge the write data into the current image; unselected lanes keep their bits
  assign ctrl_m = (ctrl_img & ~wmask) | (dat_i & wmask);
  assign thr_m = (thr_img & ~wmask) | (dat_i & wmask);

  // one wait state: ack follows the request by one edge and lasts one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= acc;
  end

  // read data; unmapped words answer zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (acc && !we_i)
    begin
      case (adr_i)
        `IOC_CTRL_OFS: dat_o <= ctrl_img;
        `IOC_THR_OFS: dat_o <= thr_img;
        `IOC_STAT_OFS: dat_o <= stat_img;
        `IOC_PEAK_A_OFS: dat_o <= {16'h0, peak_q[0]};
        `IOC_PEAK_B_OFS: dat_o <= {16'h0, peak_q[1]};
        `IOC_PEAK_C_OFS: dat_o <= {16'h0, peak_q[2]};
        default: dat_o <= 32'h0;
      endcase
    end
  end

  // operation selector, off after reset; the reserved code acts as off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_q <= ioc_trip_pkg::MODE_OFF;
    else if (wr && adr_i == `IOC_CTRL_OFS)
      mode_q <= ioc_trip_pkg::mode_e'(ctrl_m[`IOC_CTRL_MODE_LSB +: `IOC_CTRL_MODE_W]);
  end

  // threshold writes are clamped into range so the compare never sees a bad setting
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      thr_q <= `IOC_THR_RST;
    else if (wr && adr_i == `IOC_THR_OFS)
    begin
      if (thr_m < 32'(`IOC_THR_MIN))
        thr_q <= `IOC_THR_MIN;
      else if (thr_m > 32'(`IOC_THR_MAX))
        thr_q <= `IOC_THR_MAX;
      else
        thr_q <= thr_m[`IOC_THR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peak window and effective threshold

  logic [7:0] win_q;
  logic win_end;
  logic [16:0] eff_thr;
  logic [2:0] over;
  logic active;

  assign win_end = (win_q == `IOC_PEAK_WINDOW - 8'h01);
  // doubling widens by one bit so 2 x 3000 never wraps
  assign eff_thr = dbl_q ? {4'h0, thr_q, 1'b0} : {5'h0, thr_q};
  assign active = !dis_q && (mode_q == ioc_trip_pkg::MODE_PEAK
                             || mode_q == ioc_trip_pkg::MODE_FUND);

  // window counter advances once per sample set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      win_q <= 8'h0;
    else if (sample_strobe_i)
      win_q <= win_end ? 8'h0 : win_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-phase peak selection and instantaneous compare

  logic [15:0] peak_d [3];

  generate
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
      logic [15:0] mag;
      logic [15:0] sel_val;

      // magnitude of a signed sample; -32768 maps to 32768 as unsigned
      assign mag = meas_i[p].sample[15] ? 16'(-meas_i[p].sample) : 16'(meas_i[p].sample);
      // a new window starts from the fresh sample so old faults age out
      assign peak_d[p] = (win_q == 8'h0 || mag > peak_q[p]) ? mag : peak_q[p];
      assign sel_val = (mode_q == ioc_trip_pkg::MODE_PEAK) ? peak_d[p]
                                                           : meas_i[p].fund_rms;
      assign over[p] = {1'b0, sel_val} > eff_thr;

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          peak_q[p] <= 16'h0;
        else if (sample_strobe_i)
          peak_q[p] <= peak_d[p];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // trip outputs

  // no delay beyond the one register stage; held until the next sample set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trip_o <= '0;
    else if (sample_strobe_i)
    begin
      trip_o.phase <= active ? over : 3'h0;
      trip_o.general <= active && (|over);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  off_clears_a: assert property (
    sample_strobe_i && mode_q != ioc_trip_pkg::MODE_PEAK
      && mode_q != ioc_trip_pkg::MODE_FUND |=> trip_o == '0)
    else $error("trip raised while selector off");

  thr_range_a: assert property (
    thr_q >= `IOC_THR_MIN && thr_q <= `IOC_THR_MAX)
    else $error("threshold out of range");

  double_thr_a: assert property (
    dbl_q |-> eff_thr == 17'(thr_q) * 17'h2)
    else $error("doubled threshold wrong");

  disable_clears_a: assert property (
    sample_strobe_i && dis_q |=> trip_o == '0)
    else $error("trip raised while disabled");

  peak_trip_a: assert property (
    sample_strobe_i && active && mode_q == ioc_trip_pkg::MODE_PEAK
      && {1'b0, peak_d[0]} > eff_thr |=> trip_o.phase[0])
    else $error("phase a peak trip missed");

  fund_trip_a: assert property (
    sample_strobe_i && active && mode_q == ioc_trip_pkg::MODE_FUND
      && {1'b0, meas_i[1].fund_rms} <= eff_thr |=> !trip_o.phase[1])
    else $error("phase b fundamental trip wrong");

  peak_hold_a: assert property (
    sample_strobe_i && win_q != 8'h0 |=> peak_q[2] >= $past(peak_q[2]))
    else $error("phase c peak fell inside window");

  general_or_a: assert property (
    ##1 trip_o.general == (|trip_o.phase))
    else $error("general trip not OR of phases");

  hold_stable_a: assert property (
    !sample_strobe_i |=> $stable(trip_o))
    else $error("trips changed without strobe");

  bus_ack_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not one cycle");

endmodule : instant_overcurrent_function
`default_nettype wire

/* File: sample_source.sv */
// front end model that hands sample sets to the trip block
`timescale 1ns/1ps
`default_nettype none
module sample_source (
  input wire logic clk_i,
  output logic strobe_o,
  output ioc_trip_pkg::phase_meas_s [2:0] meas_o
);
  initial
  begin
    strobe_o = 1'b0;
    meas_o = '0;
  end
  // one strobe per set; rms comes from the fourier stage here, the block never derives it
  task automatic send(input ioc_trip_pkg::phase_meas_s [2:0] m);
    @(posedge clk_i);
    strobe_o <= 1'b1;
    meas_o <= m;
    @(posedge clk_i);
    strobe_o <= 1'b0;
    meas_o <= ~m; // stale set must not look valid
  endtask : send
endmodule : sample_source
`default_nettype wire

/* File: instant_overcurrent_function_tb.sv */
// testbench of the overcurrent trip block
`timescale 1ns/1ps
`default_nettype none
`include "ioc_trip_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module instant_overcurrent_function_tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, strobe, dis, dbl;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] pk [3];
  logic [1:0] mode;
  logic [12:0] thr;
  ioc_trip_pkg::phase_meas_s [2:0] meas;
  ioc_trip_pkg::trip_s trip_o;
  int num_errors = 0;
  int total_checks = 0;
  int cnt = 0;
  instant_overcurrent_function u_instant_overcurrent_function (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sample_strobe_i(strobe), .meas_i(meas),
    .function_disable_input_i(dis), .threshold_double_input_i(dbl), .trip_o(trip_o));
  sample_source u_sample_source (.clk_i(clk_i), .strobe_o(strobe), .meas_o(meas));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // classic cycle held until ack is seen at an edge; bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (i = 0; i < 20 && ack_o !== 1'b1; i++)
      @(posedge clk_i);
    if (i == 20)
    begin
      num_errors++;
      finish_test();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic thw(input logic [31:0] d, input logic [12:0] e);
    wb(1'b1, `IOC_THR_OFS, d);
    wb(1'b0, `IOC_THR_OFS, 32'h0);
    `CHK(q, {19'h0, e})
    thr = e;
  endtask : thw
  task automatic md(input logic [1:0] m);
    wb(1'b1, `IOC_CTRL_OFS, {30'h0, m});
    mode = m;
  endtask : md
  // pins pass a two-flop synchroniser, so allow three edges
  task automatic pins(input logic d, input logic b);
    @(posedge clk_i);
    dis <= d;
    dbl <= b;
    repeat (3) @(posedge clk_i);
  endtask : pins
  // send a set, update the reference peak window, compare trips, peaks and hold
  task automatic smp(input logic [15:0] s0, s1, s2, r0, r1, r2);
    ioc_trip_pkg::phase_meas_s [2:0] m;
    logic [2:0] e;
    logic [15:0] v;
    int k;
    m = {s2, r2, s1, r1, s0, r0};
    u_sample_source.send(m);
    for (k = 0; k < 3; k++)
    begin
      v = m[k].sample[15] ? -m[k].sample : m[k].sample;
      pk[k] = (cnt == 0 || v > pk[k]) ? v : pk[k];
      v = (mode == 2'h1) ? pk[k] : m[k].fund_rms;
      e[k] = !dis && (mode == 2'h1 || mode == 2'h2) && v > (dbl ? 2 * thr : thr);
    end
    cnt = (cnt + 1) % 20;
    @(posedge clk_i);
    `CHK(trip_o.phase, e)
    `CHK(trip_o.general, |e)
    for (k = 0; k < 3; k++)
    begin
      wb(1'b0, `IOC_PEAK_A_OFS + 8'(4 * k), 32'h0);
      `CHK(q[15:0], pk[k])
    end
    `CHK(trip_o, {|e, e})
  endtask : smp
  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    dis = 1'b0;
    dbl = 1'b0;
    mode = 2'h0;
    thr = 13'h0c8;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(trip_o, 4'h0)
    wb(1'b0, `IOC_THR_OFS, 32'h0);
    `CHK(q, 32'hc8)
    smp(16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff);
    thw(32'h5, 13'h014);
    thw(32'hfff, 13'hbb8);
    thw(32'h64, 13'h064);
    $display("test reset and threshold done");
    md(2'h2);
    smp(16'h0, 16'h0, 16'h0, 16'h65, 16'h64, 16'h0);
    pins(1'b0, 1'b1);
    smp(16'h0, 16'h0, 16'h0, 16'hc8, 16'hc9, 16'h0);
    wb(1'b0, `IOC_STAT_OFS, 32'h0);
    `CHK(q[5:0], 6'h2a)
    pins(1'b1, 1'b1);
    smp(16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff, 16'hffff);
    pins(1'b0, 1'b0);
    $display("test fundamental done");
    md(2'h1);
    for (int i = 0; i < 22; i++)
      smp(16'(-(i * 8)), 16'(i * 5), 16'h64, 16'h7fff, 16'h0, 16'h7fff);
    $display("test peak done");
    // reset in mid-run while trips stand: outputs and settings return to defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(trip_o, 4'h0)
    wb(1'b0, `IOC_CTRL_OFS, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b0, `IOC_THR_OFS, 32'h0);
    `CHK(q, 32'hc8)
    mode = 2'h0;
    thr = 13'h0c8;
    cnt = 0;
    $display("test mid-run reset done");
    md(2'h3);
    smp(16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff);
    wb(1'b0, `IOC_CTRL_OFS, 32'h0);
    `CHK(q, 32'h3)
    wb(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    $display("test reserved done");
    finish_test();
  end
endmodule : instant_overcurrent_function_tb
`default_nettype wire
